// ---- rtl/emulator_break_trace_unit.sv ----
module emulator_break_trace_unit #(
   parameter int TRACE_DEPTH_P = break_trace_pkg::TRACE_DEPTH,
   parameter int QDEPTH_P = break_trace_pkg::QUEUE_DEPTH
) (
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic ce,
   input break_trace_pkg::av_req_t av_req,
   output break_trace_pkg::av_rsp_t av_rsp,
   input break_trace_pkg::cpu_bus_t cpu,
   output logic emu_run,
   output logic break_match,
   output logic irq
);
   import break_trace_pkg::*;

   localparam int PW = $clog2(TRACE_DEPTH_P + 1);
   localparam int QW = $clog2(QDEPTH_P + 1);

   typedef struct packed {
      logic trace_en;
      logic run;
      logic trace_on;
      logic brk;
      logic irq;
      logic [IRQ_W-1:0] istat;
      logic [IRQ_W-1:0] imask;
      unit_cfg_t [UNITS-1:0] cfg;
      logic [UNITS-1:0][ADDR_W-1:0] cmp_a;
      logic [UNITS-1:0][ADDR_W-1:0] cmp_d;
      logic [ADDR_W-1:0] lat_addr;
      logic [CYC_W-1:0] lat_cyc;
      logic [1:0] lat_seg;
      logic [QDEPTH_P-1:0][ADDR_W-1:0] fq;
      logic [QW-1:0] fq_cnt;
      logic [PW-1:0] wr_ptr;
      logic [PW-1:0] fill;
      logic [PW-1:0] rd_idx;
      logic waitreq;
      logic [31:0] rdata;
   } state_t;

   state_t s_q, s_d;
   trace_frame_t mem [TRACE_DEPTH_P];
   trace_frame_t frame;
   logic tw;
   logic do_wr;
   logic bm_hit;
   logic [UNITS-1:0] m;
   sample_t smp;

   // address phase is latched so data-phase matching sees the full access
   assign smp = '{addr: s_q.lat_addr, data: cpu.ad, cyc: s_q.lat_cyc, seg: s_q.lat_seg};

   // a write commits on the edge that the master sees waitrequest low
   assign do_wr = av_req.write && !s_q.waitreq;
   assign bm_hit = do_wr && (av_req.address == OFS_BMAP);

   for (genvar k = 0; k < UNITS; k++) begin : g_unit
      unit_matcher u_match (
         .sys_clk(sys_clk),
         .arst_n(arst_n),
         .ce(ce),
         .cfg(s_q.cfg[k]),
         .cmp_a(s_q.cmp_a[k]),
         .cmp_d(s_q.cmp_d[k]),
         .smp(smp),
         .bm_we(bm_hit && (av_req.writedata[BM_UNIT +: 2] == 2'(k))),
         .bm_data(av_req.writedata[BM_DATA]),
         .bm_idx(av_req.writedata[WIN_W-1:0]),
         .bm_val(av_req.writedata[BM_VAL]),
         .match(m[k])
      );
   end

   always_comb begin
      logic [UNITS-1:0] ux;
      logic [UNITS-1:0] un;
      logic pop;
      logic push;
      logic brk_now;
      logic start;
      logic stop;
      logic gate;
      logic [31:0] wd;
      logic [7:0] a;
      ux = '0;
      un = '0;
      pop = 1'b0;
      push = 1'b0;
      brk_now = 1'b0;
      start = 1'b0;
      stop = 1'b0;
      gate = 1'b0;
      wd = '0;
      a = av_req.address;
      s_d = s_q;
      tw = 1'b0;
      frame = '0;

      // one wait cycle for every access, reads and writes alike
      s_d.waitreq = 1'b1;
      if ((av_req.read || av_req.write) && s_q.waitreq) begin
         s_d.waitreq = 1'b0;
         s_d.rdata = '0;
         if (a == OFS_CTRL) begin
            s_d.rdata = {30'h0, s_q.run, s_q.trace_en};
         end else if (a == OFS_STATUS) begin
            s_d.rdata = {29'h0, s_q.brk, s_q.trace_on, s_q.run};
         end else if (a == OFS_ISTAT) begin
            s_d.rdata = 32'(s_q.istat);
         end else if (a == OFS_IMASK) begin
            s_d.rdata = 32'(s_q.imask);
         end else if (a == OFS_TINFO) begin
            s_d.rdata[15:0] = 16'(s_q.wr_ptr);
            s_d.rdata[31:16] = 16'(s_q.fill);
         end else if (a == OFS_TIDX) begin
            s_d.rdata = 32'(s_q.rd_idx);
         end else if (a == OFS_TDATA) begin
            if (32'(s_q.rd_idx) < TRACE_DEPTH_P) begin
               s_d.rdata = 32'(mem[s_q.rd_idx]);
            end
         end
         for (int k = 0; k < UNITS; k++) begin
            if (a == unit_ofs(k, OFS_CFG)) begin
               s_d.rdata = 32'(s_q.cfg[k]);
            end else if (a == unit_ofs(k, OFS_CMPA)) begin
               s_d.rdata = 32'(s_q.cmp_a[k]);
            end else if (a == unit_ofs(k, OFS_CMPD)) begin
               s_d.rdata = 32'(s_q.cmp_d[k]);
            end
         end
      end

      if (do_wr) begin
         if (a == OFS_CTRL) begin
            wd = be_merge({30'h0, s_q.run, s_q.trace_en}, av_req.writedata,
                          av_req.byteenable);
            s_d.trace_en = wd[CTRL_TEN];
            if (wd[CTRL_RUN] && !s_q.run) begin
               // trace store and pointers deliberately left as they are
               s_d.run = 1'b1;
               s_d.brk = 1'b0;
               s_d.fq_cnt = '0;
            end else if (!wd[CTRL_RUN]) begin
               s_d.run = 1'b0;
            end
         end else if (a == OFS_ISTAT) begin
            wd = be_merge(32'h0, av_req.writedata, av_req.byteenable);
            s_d.istat = s_q.istat & ~wd[IRQ_W-1:0];
         end else if (a == OFS_IMASK) begin
            wd = be_merge(32'(s_q.imask), av_req.writedata, av_req.byteenable);
            s_d.imask = wd[IRQ_W-1:0];
         end else if (a == OFS_TIDX) begin
            wd = be_merge(32'(s_q.rd_idx), av_req.writedata, av_req.byteenable);
            s_d.rd_idx = wd[PW-1:0];
         end
         for (int k = 0; k < UNITS; k++) begin
            if (a == unit_ofs(k, OFS_CFG)) begin
               wd = be_merge(32'(s_q.cfg[k]), av_req.writedata, av_req.byteenable);
               s_d.cfg[k] = unit_cfg_t'(wd[CFG_W-1:0]);
            end else if (a == unit_ofs(k, OFS_CMPA)) begin
               wd = be_merge(32'(s_q.cmp_a[k]), av_req.writedata, av_req.byteenable);
               s_d.cmp_a[k] = wd[ADDR_W-1:0];
            end else if (a == unit_ofs(k, OFS_CMPD)) begin
               wd = be_merge(32'(s_q.cmp_d[k]), av_req.writedata, av_req.byteenable);
               s_d.cmp_d[k] = wd[ADDR_W-1:0];
            end
         end
      end

      // target bus is watched only while emulation runs
      if (s_q.run) begin
         if (cpu.addr_valid) begin
            s_d.lat_addr = cpu.ad;
            s_d.lat_cyc = cpu.cyc;
            s_d.lat_seg = cpu.seg;
         end
         pop = (cpu.qop == QOP_FIRST) || (cpu.qop == QOP_NEXT);
         push = cpu.data_valid && (s_q.lat_cyc == CYC_FETCH);

         // only a byte leaving the queue can break, not its prefetch
         if (pop && (s_q.fq_cnt != '0)) begin
            for (int k = 0; k < UNITS; k++) begin
               ux[k] = s_q.cfg[k].enable && s_q.cfg[k].exec &&
                       (s_q.fq[0] == s_q.cmp_a[k]);
            end
         end
         for (int k = 0; k < UNITS; k++) begin
            un[k] = m[k] && cpu.data_valid;
         end

         // fetch address shadow of the prefetch queue
         if (cpu.qop == QOP_FLUSH) begin
            s_d.fq_cnt = '0;
         end else if (pop && (s_q.fq_cnt != '0)) begin
            for (int i = 0; i < QDEPTH_P - 1; i++) begin
               s_d.fq[i] = s_q.fq[i+1];
            end
            s_d.fq_cnt = s_q.fq_cnt - 1'b1;
         end
         // a push beyond depth is dropped; the real queue cannot overfill
         if (push && (32'(s_d.fq_cnt) < QDEPTH_P)) begin
            s_d.fq[s_d.fq_cnt] = s_q.lat_addr;
            s_d.fq_cnt = s_d.fq_cnt + 1'b1;
         end

         if (s_q.cfg[U_BP0].pair) begin
            brk_now = un[U_BP0] && un[U_BP1];
         end else begin
            brk_now = un[U_BP0] || un[U_BP1];
         end
         brk_now = brk_now || ux[U_BP0] || ux[U_BP1];

         start = ux[U_TSTART] || un[U_TSTART];
         stop = ux[U_TSTOP] || un[U_TSTOP];
         s_d.trace_on = (s_q.trace_on || start) && !stop;
         // with no start tracepoint armed the whole run is traced
         gate = !s_q.cfg[U_TSTART].enable || s_q.trace_on || start;

         frame.ad = cpu.ad;
         frame.cyc = cpu.cyc;
         frame.seg = cpu.seg;
         frame.qop = cpu.qop;
         // at most one frame per clock, none on idle clocks; queue-only frame when no bus phase is due
         if (cpu.addr_valid) begin
            frame.phase = PH_ADDR;
         end else if (cpu.data_valid) begin
            frame.phase = PH_DATA;
         end else begin
            frame.phase = PH_QUEUE;
         end
         tw = s_q.trace_en && gate &&
              (cpu.addr_valid || cpu.data_valid || (cpu.qop != QOP_NONE));

         if (brk_now) begin
            // halt here: no frame is written after the break cycle
            s_d.run = 1'b0;
            s_d.brk = 1'b1;
         end
      end

      if (tw) begin
         if (32'(s_q.wr_ptr) == TRACE_DEPTH_P - 1) begin
            s_d.wr_ptr = '0;
         end else begin
            s_d.wr_ptr = s_q.wr_ptr + 1'b1;
         end
         if (32'(s_q.fill) < TRACE_DEPTH_P) begin
            s_d.fill = s_q.fill + 1'b1;
         end
      end

      // hardware set wins over a same-cycle software clear
      s_d.istat[IRQ_BREAK] = s_d.istat[IRQ_BREAK] || brk_now;
      s_d.istat[IRQ_TSTART] = s_d.istat[IRQ_TSTART] || start;
      s_d.istat[IRQ_TSTOP] = s_d.istat[IRQ_TSTOP] || stop;
      s_d.irq = |(s_d.istat & s_d.imask);
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         s_q <= '0;
         s_q.trace_en <= CTRL_RST[CTRL_TEN];
         s_q.waitreq <= 1'b1;
      end else if (ce) begin
         s_q <= s_d;
      end
   end

   // store has no reset: contents survive runs and soft restarts
   always_ff @(posedge sys_clk) begin
      if (ce && tw) begin
         mem[s_q.wr_ptr] <= frame;
      end
   end

   assign av_rsp = '{waitrequest: s_q.waitreq, readdata: s_q.rdata};
   assign emu_run = s_q.run;
   assign break_match = s_q.brk;
   assign irq = s_q.irq;

endmodule

// ---- rtl/break_trace_pkg.sv ----
// Behaviour
// - two breakpoints; halt on either match, or on both non-exec matches with pair set
// - each breakpoint is execution or non-execution
// - execution break on queue consume, not prefetch
// - exact address or bitmap within 1024-byte window
// - address above or below 20-bit compare value
// - qualify on any mix of cycle types
// - data matched like address: exact, window, compare
// - match when chosen segment forms the address
// - one or both registers; criteria freely combined
// - external break match output on every break
// - two tracepoints start and stop trace collection
// - frame at address phase and data phase
// - extra frames for instruction queue activity
// - frame holds 20 bus lines plus status
// - 1023-frame circular store, oldest overwritten
// - trace kept across runs, never cleared at start
// - trace on by default, host may disable, readable
package break_trace_pkg;

   localparam int ADDR_W = 20;
   localparam int WIN_W = 10;
   localparam int TRACE_DEPTH = 1023;
   localparam int QUEUE_DEPTH = 4;
   localparam int UNITS = 4;
   localparam int CYC_W = 3;
   localparam int CFG_W = 19;
   localparam int IRQ_W = 3;

   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_ISTAT = 8'h08;
   localparam logic [7:0] OFS_IMASK = 8'h0c;
   localparam logic [7:0] OFS_UNIT = 8'h10;
   localparam logic [7:0] OFS_UNIT_STRIDE = 8'h10;
   localparam logic [7:0] OFS_CFG = 8'h00;
   localparam logic [7:0] OFS_CMPA = 8'h04;
   localparam logic [7:0] OFS_CMPD = 8'h08;
   localparam logic [7:0] OFS_BMAP = 8'h50;
   localparam logic [7:0] OFS_TINFO = 8'h54;
   localparam logic [7:0] OFS_TIDX = 8'h58;
   localparam logic [7:0] OFS_TDATA = 8'h5c;

   localparam int CTRL_TEN = 0;
   localparam int CTRL_RUN = 1;
   localparam logic [1:0] CTRL_RST = 2'h1;
   localparam int IRQ_BREAK = 0;
   localparam int IRQ_TSTART = 1;
   localparam int IRQ_TSTOP = 2;
   localparam int BM_VAL = 10;
   localparam int BM_DATA = 11;
   localparam int BM_UNIT = 12;

   localparam int U_BP0 = 0;
   localparam int U_BP1 = 1;
   localparam int U_TSTART = 2;
   localparam int U_TSTOP = 3;

   // 0 mem rd, 1 mem wr, 2 io rd, 3 io wr, 4 fetch, 5 halt, 6 int ack
   localparam logic [2:0] CYC_FETCH = 3'h4;
   localparam logic [2:0] CYC_NONE = 3'h7;
   localparam logic [1:0] QOP_NONE = 2'h0;
   localparam logic [1:0] QOP_FIRST = 2'h1;
   localparam logic [1:0] QOP_FLUSH = 2'h2;
   localparam logic [1:0] QOP_NEXT = 2'h3;
   localparam logic [1:0] PH_ADDR = 2'h0;
   localparam logic [1:0] PH_DATA = 2'h1;
   localparam logic [1:0] PH_QUEUE = 2'h2;

   typedef enum logic [2:0] {MM_OFF, MM_EXACT, MM_WINDOW, MM_ABOVE, MM_BELOW} match_mode_t;

   typedef struct packed {
      logic pair;
      logic [1:0] seg_sel;
      logic seg_en;
      logic [6:0] cyc_mask;
      match_mode_t data_mode;
      match_mode_t addr_mode;
      logic exec;
      logic enable;
   } unit_cfg_t;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [ADDR_W-1:0] data;
      logic [CYC_W-1:0] cyc;
      logic [1:0] seg;
   } sample_t;

   typedef struct packed {
      logic [ADDR_W-1:0] ad;
      logic addr_valid;
      logic data_valid;
      logic [CYC_W-1:0] cyc;
      logic [1:0] seg;
      logic [1:0] qop;
   } cpu_bus_t;

   typedef struct packed {
      logic [1:0] qop;
      logic [1:0] seg;
      logic [CYC_W-1:0] cyc;
      logic [1:0] phase;
      logic [ADDR_W-1:0] ad;
   } trace_frame_t;

   typedef struct packed {
      logic read;
      logic write;
      logic [7:0] address;
      logic [31:0] writedata;
      logic [3:0] byteenable;
   } av_req_t;

   typedef struct packed {
      logic waitrequest;
      logic [31:0] readdata;
   } av_rsp_t;

   function automatic logic value_ok(input match_mode_t m, input logic [ADDR_W-1:0] v,
                                     input logic [ADDR_W-1:0] c,
                                     input logic [(1<<WIN_W)-1:0] map);
      case (m)
         MM_OFF: return 1'b1;
         MM_EXACT: return v == c;
         MM_WINDOW: return (v[ADDR_W-1:WIN_W] == c[ADDR_W-1:WIN_W]) && map[v[WIN_W-1:0]];
         MM_ABOVE: return v > c;
         MM_BELOW: return v < c;
         default: return 1'b0;
      endcase
   endfunction

   function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
                                            input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            r[b*8 +: 8] = wd[b*8 +: 8];
         end
      end
      return r;
   endfunction

   function automatic logic [7:0] unit_ofs(input int k, input logic [7:0] ofs);
      return 8'(OFS_UNIT + 8'(k) * OFS_UNIT_STRIDE + ofs);
   endfunction

endpackage

// ---- rtl/unit_matcher.sv ----
module unit_matcher (
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic ce,
   input break_trace_pkg::unit_cfg_t cfg,
   input wire logic [break_trace_pkg::ADDR_W-1:0] cmp_a,
   input wire logic [break_trace_pkg::ADDR_W-1:0] cmp_d,
   input break_trace_pkg::sample_t smp,
   input wire logic bm_we,
   input wire logic bm_data,
   input wire logic [break_trace_pkg::WIN_W-1:0] bm_idx,
   input wire logic bm_val,
   output logic match
);
   import break_trace_pkg::*;

   typedef struct packed {
      logic [(1<<WIN_W)-1:0] amap;
      logic [(1<<WIN_W)-1:0] dmap;
   } map_t;

   map_t s_q, s_d;
   logic cyc_ok;

   always_comb begin
      s_d = s_q;
      if (bm_we) begin
         if (bm_data) begin
            s_d.dmap[bm_idx] = bm_val;
         end else begin
            s_d.amap[bm_idx] = bm_val;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         s_q <= '0;
      end else if (ce) begin
         s_q <= s_d;
      end
   end

   // empty mask means any cycle type, idle included; with any mask bit set idle status never qualifies
   assign cyc_ok = (cfg.cyc_mask == 7'h00) ||
                   ((smp.cyc != CYC_NONE) && cfg.cyc_mask[smp.cyc]);

   assign match = cfg.enable && !cfg.exec
                  && value_ok(cfg.addr_mode, smp.addr, cmp_a, s_q.amap)
                  && value_ok(cfg.data_mode, smp.data, cmp_d, s_q.dmap)
                  && cyc_ok
                  && (!cfg.seg_en || smp.seg == cfg.seg_sel);

endmodule

// ---- tb/break_trace_props.sv ----
module break_trace_props #(
   parameter int TRACE_DEPTH_P = 1023,
   parameter int QDEPTH_P = 4
) (
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic ce,
   input break_trace_pkg::av_req_t av_req,
   input break_trace_pkg::av_rsp_t av_rsp,
   input break_trace_pkg::cpu_bus_t cpu,
   input wire logic emu_run,
   input wire logic break_match,
   input wire logic irq
);
   timeunit 1ns;
   timeprecision 1ns;
   import break_trace_pkg::*;
   logic start_commit;
   // host write that sets the run bit, taken at the edge where waitrequest is low
   assign start_commit = ce && av_req.write && !av_rsp.waitrequest &&
                         av_req.address == OFS_CTRL && av_req.byteenable[0] &&
                         av_req.writedata[CTRL_RUN];
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!arst_n);
   sequence s_access;
      av_rsp.waitrequest ##1 !av_rsp.waitrequest ##1 av_rsp.waitrequest;
   endsequence
   sequence s_halt;
      $rose(break_match) ##0 $fell(emu_run);
   endsequence
   property p_access;
      ce && (av_req.read || av_req.write) && av_rsp.waitrequest |-> s_access;
   endproperty
   property p_wait_one;
      ce && !av_rsp.waitrequest |=> av_rsp.waitrequest;
   endproperty
   property p_read_hold;
      !$stable(av_rsp.readdata) |-> $fell(av_rsp.waitrequest);
   endproperty
   property p_break_halts;
      $rose(break_match) |-> s_halt;
   endproperty
   property p_break_cause;
      $rose(break_match) |-> $past(emu_run) &&
         $past(cpu.addr_valid || cpu.data_valid || cpu.qop != QOP_NONE);
   endproperty
   property p_match_holds;
      break_match && !start_commit |=> break_match;
   endproperty
   property p_stopped;
      !emu_run && !start_commit |=> !emu_run;
   endproperty
   property p_start;
      start_commit && !emu_run |=> emu_run && !break_match;
   endproperty
   property p_match_stopped;
      break_match |-> !emu_run;
   endproperty
   a_access: assert property (p_access) else $error("access not answered in one cycle");
   a_wait_one: assert property (p_wait_one) else $error("waitrequest low too long");
   a_read_hold: assert property (p_read_hold) else $error("readdata moved");
   a_break_halts: assert property (p_break_halts) else $error("match without halt");
   a_break_cause: assert property (p_break_cause) else $error("match without cause");
   a_match_holds: assert property (p_match_holds) else $error("match output dropped");
   a_stopped: assert property (p_stopped) else $error("run started by itself");
   a_start: assert property (p_start) else $error("run start not honoured");
   a_match_stopped: assert property (p_match_stopped) else $error("match while running");
endmodule
bind emulator_break_trace_unit break_trace_props #(
   .TRACE_DEPTH_P(TRACE_DEPTH_P), .QDEPTH_P(QDEPTH_P)) props_u (.sys_clk(sys_clk),
   .arst_n(arst_n), .ce(ce), .av_req(av_req), .av_rsp(av_rsp), .cpu(cpu),
   .emu_run(emu_run), .break_match(break_match), .irq(irq));

// ---- tb/cpu_bus_model.sv ----
module cpu_bus_model (
   input wire logic sys_clk,
   output break_trace_pkg::cpu_bus_t cpu
);
   timeunit 1ns;
   timeprecision 1ns;
   import break_trace_pkg::*;
   initial cpu = '{ad: 20'h5a5a5, addr_valid: 1'b0, data_valid: 1'b0, cyc: CYC_NONE,
                   seg: 2'h0, qop: QOP_NONE};
   // address phase strictly before data phase; status only valid with the address
   task automatic bus_cycle(input sample_t s);
      @(posedge sys_clk);
      cpu <= '{ad: s.addr, addr_valid: 1'b1, data_valid: 1'b0, cyc: s.cyc, seg: s.seg,
               qop: QOP_NONE};
      @(posedge sys_clk);
      cpu <= '{ad: s.data, addr_valid: 1'b0, data_valid: 1'b1, cyc: CYC_NONE, seg: ~s.seg,
               qop: QOP_NONE};
      @(posedge sys_clk);
      // released lines show the inverse so a stale value never looks valid
      cpu <= '{ad: ~s.data, addr_valid: 1'b0, data_valid: 1'b0, cyc: CYC_NONE, seg: s.seg,
               qop: QOP_NONE};
   endtask
   task automatic queue_op(input logic [1:0] q);
      @(posedge sys_clk);
      cpu <= '{ad: ~cpu.ad, addr_valid: 1'b0, data_valid: 1'b0, cyc: CYC_NONE, seg: cpu.seg,
               qop: q};
      @(posedge sys_clk);
      cpu <= '{ad: ~cpu.ad, addr_valid: 1'b0, data_valid: 1'b0, cyc: CYC_NONE, seg: cpu.seg,
               qop: QOP_NONE};
   endtask
endmodule

// ---- tb/tb_top.sv ----
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import break_trace_pkg::*;
   logic sys_clk;
   logic arst_n;
   logic ce;
   av_req_t av_req;
   av_rsp_t av_rsp;
   cpu_bus_t cpu;
   logic emu_run;
   logic break_match;
   logic irq;
   logic irq_exp;
   logic [31:0] rdata;
   int num_errors;
   int samples_checked;
   // short store so wrap-around and saturation show within a few runs
   emulator_break_trace_unit #(.TRACE_DEPTH_P(15), .QDEPTH_P(4)) dut_u (.sys_clk(sys_clk),
      .arst_n(arst_n), .ce(ce), .av_req(av_req), .av_rsp(av_rsp), .cpu(cpu),
      .emu_run(emu_run), .break_match(break_match), .irq(irq));
   cpu_bus_model cpu_m (.sys_clk(sys_clk), .cpu(cpu));
   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end
   task automatic give_verdict();
      if (num_errors == 0 && samples_checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic av_xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                          output logic [31:0] rd);
      int n;
      @(posedge sys_clk);
      av_req <= '{read: !wr, write: wr, address: a, writedata: wd, byteenable: 4'hf};
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (av_rsp.waitrequest !== 1'b0 && n < 50);
      if (n >= 50) begin
         num_errors++;
      end
      rd = av_rsp.readdata;
      av_req <= '0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] x;
      av_xfer(1'b1, a, d, x);
   endtask
   task automatic rd(input logic [7:0] a);
      av_xfer(1'b0, a, 32'h0, rdata);
   endtask
   task automatic run_case(input logic [7:0] u, input logic [31:0] cfg,
                           input logic [31:0] ca, input logic [31:0] cd,
                           input sample_t miss, input sample_t hit);
      logic [7:0] base;
      base = 8'(OFS_UNIT + OFS_UNIT_STRIDE * u);
      wr(8'(base + OFS_CMPA), ca);
      wr(8'(base + OFS_CMPD), cd);
      wr(8'(base + OFS_CFG), cfg);
      wr(OFS_CTRL, 32'h3);
      cpu_m.bus_cycle(miss);
      @(negedge sys_clk);
      check(32'({emu_run, break_match}), 32'h2);
      cpu_m.bus_cycle(hit);
      @(negedge sys_clk);
      check(32'({emu_run, break_match, irq}), 32'({2'b01, irq_exp}));
      wr(8'(base + OFS_CFG), 32'h0);
   endtask
   initial begin
      #2_000_000;
      num_errors++;
      give_verdict();
   end
   initial begin
      num_errors = 0;
      samples_checked = 0;
      ce = 1'b1;
      arst_n = 1'b0;
      av_req = '0;
      repeat (8) @(posedge sys_clk);
      arst_n <= 1'b1;
      rd(OFS_CTRL);
      check(rdata, 32'h1);
      rd(OFS_STATUS);
      check(rdata, 32'h0);
      wr(8'hf0, 32'hffffffff);
      rd(8'hf0);
      check(rdata, 32'h0);
      wr(OFS_BMAP, 32'h1405);
      wr(OFS_BMAP, 32'h1c03);
      wr(OFS_IMASK, 32'h1);
      irq_exp = 1'b1;
      run_case(8'h0, 32'h205, 32'h12345, 32'h0, '{20'h12345, 20'h0, 3'h0, 2'h0},
               '{20'h12345, 20'h0, 3'h1, 2'h0});
      cpu_m.bus_cycle('{20'h12345, 20'h0, 3'h1, 2'h0});
      rd(OFS_STATUS);
      check(rdata & 32'h5, 32'h4);
      rd(OFS_TINFO);
      check(rdata, 32'h00040004);
      rd(OFS_ISTAT);
      check(32'(rdata[IRQ_BREAK]), 32'h1);
      wr(OFS_ISTAT, 32'h1);
      @(negedge sys_clk);
      check(32'(irq), 32'h0);
      wr(OFS_IMASK, 32'h0);
      irq_exp = 1'b0;
      run_case(8'h1, 32'h5, 32'h12345, 32'h0, '{20'h12344, 20'h0, 3'h0, 2'h0},
               '{20'h12345, 20'h0, 3'h0, 2'h0});
      run_case(8'h1, 32'h9, 32'h40000, 32'h0, '{20'h40004, 20'h0, 3'h0, 2'h0},
               '{20'h40005, 20'h0, 3'h0, 2'h0});
      run_case(8'h1, 32'hd, 32'h80000, 32'h0, '{20'h80000, 20'h0, 3'h0, 2'h0},
               '{20'h80001, 20'h0, 3'h0, 2'h0});
      run_case(8'h1, 32'h11, 32'h80000, 32'h0, '{20'h80000, 20'h0, 3'h0, 2'h0},
               '{20'h7ffff, 20'h0, 3'h0, 2'h0});
      run_case(8'h1, 32'h21, 32'h0, 32'h0beef, '{20'h0, 20'h0beee, 3'h0, 2'h0},
               '{20'h0, 20'h0beef, 3'h0, 2'h0});
      run_case(8'h1, 32'h41, 32'h0, 32'h00400, '{20'h0, 20'h00402, 3'h0, 2'h0},
               '{20'h0, 20'h00403, 3'h0, 2'h0});
      run_case(8'h1, 32'h28001, 32'h0, 32'h0, '{20'h0, 20'h0, 3'h0, 2'h1},
               '{20'h0, 20'h0, 3'h0, 2'h2});
      // exec break: prefetch alone must not halt, only the consume of that byte
      wr(8'(OFS_UNIT + OFS_CMPA), 32'h00100);
      wr(8'(OFS_UNIT + OFS_CFG), 32'h3);
      wr(OFS_CTRL, 32'h3);
      cpu_m.bus_cycle('{20'h000ff, 20'h00090, CYC_FETCH, 2'h1});
      cpu_m.bus_cycle('{20'h00100, 20'h000cc, CYC_FETCH, 2'h1});
      cpu_m.queue_op(QOP_FIRST);
      @(negedge sys_clk);
      check(32'(emu_run), 32'h1);
      cpu_m.queue_op(QOP_NEXT);
      @(negedge sys_clk);
      check(32'({emu_run, break_match}), 32'h1);
      rd(OFS_TINFO);
      check(rdata, 32'h000f0008);
      wr(OFS_TIDX, 32'h0);
      rd(OFS_TDATA);
      check(rdata, 32'(trace_frame_t'{qop: QOP_NONE, seg: 2'h2, cyc: 3'h0, phase: PH_ADDR,
                                     ad: 20'h0}));
      wr(OFS_TIDX, 32'h7);
      rd(OFS_TDATA);
      check(32'({rdata[28:27], rdata[21:20]}), 32'({QOP_NEXT, PH_QUEUE}));
      // tracepoints gate the store; frozen clock drops a whole bus cycle
      wr(8'(OFS_UNIT + OFS_CMPA), 32'h00400);
      wr(8'(OFS_UNIT + OFS_CFG), 32'h5);
      wr(unit_ofs(U_TSTART, OFS_CMPA), 32'h00200);
      wr(unit_ofs(U_TSTART, OFS_CFG), 32'h5);
      wr(unit_ofs(U_TSTOP, OFS_CMPA), 32'h00300);
      wr(unit_ofs(U_TSTOP, OFS_CFG), 32'h5);
      wr(OFS_CTRL, 32'h3);
      cpu_m.bus_cycle('{20'h00100, 20'h0, 3'h0, 2'h0});
      cpu_m.bus_cycle('{20'h00200, 20'h0, 3'h0, 2'h0});
      rd(OFS_STATUS);
      check(rdata, 32'h3);
      ce <= 1'b0;
      cpu_m.bus_cycle('{20'h00250, 20'h0, 3'h0, 2'h0});
      ce <= 1'b1;
      cpu_m.bus_cycle('{20'h00250, 20'h0, 3'h0, 2'h0});
      cpu_m.bus_cycle('{20'h00300, 20'h0, 3'h0, 2'h0});
      cpu_m.bus_cycle('{20'h00400, 20'h0, 3'h0, 2'h0});
      @(negedge sys_clk);
      check(32'({emu_run, break_match}), 32'h1);
      rd(OFS_TINFO);
      check(rdata, 32'h000f000d);
      rd(OFS_STATUS);
      check(rdata, 32'h4);
      rd(OFS_ISTAT);
      check(rdata, 32'h7);
      give_verdict();
   end
endmodule
